// ### src/alarm_event_annunciator.sv
// alarm lists, front-panel indicator, alarm output and append-only logs
module alarm_event_annunciator
    import annunciator_pkg::*;
#(
    parameter int FLASH_HALF = FLASH_HALF_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // limit comparison results, one bit per alarm
    input wire logic [NUM_ALARMS-1:0] limit_violation,
    // operator acknowledge, one pulse per alarm bit
    input wire logic [NUM_ALARMS-1:0] ack_pulse,
    // parameter change event
    input wire logic param_chg_valid,
    input wire logic [PARAM_ID_W-1:0] param_chg_id,
    input wire logic [VALUE_W-1:0] param_chg_old,
    input wire logic [VALUE_W-1:0] param_chg_new,
    // gas composition from the supervisory link
    input wire logic gas_comp_valid,
    input wire logic [COMP_W-1:0] gas_comp_data,
    // read ports of the logs
    input wire logic [LOG_PTR_W-1:0] alog_rd_addr,
    input wire logic [LOG_PTR_W-1:0] elog_rd_addr,
    input wire logic [LOG_PTR_W-1:0] dlog_rd_addr,
    // front panel and alarm output
    output logic alarm_led,
    output logic alarm_out,
    // list state
    output logic [NUM_ALARMS-1:0] unack_list,
    output logic [NUM_ALARMS-1:0] ack_list,
    // log contents and fill counts
    output logic [ALARM_IDX_W:0] alog_rd_data,
    output logic [PARAM_ID_W+2*VALUE_W-1:0] elog_rd_data,
    output logic [COMP_W-1:0] dlog_rd_data,
    output logic [LOG_PTR_W:0] alog_count,
    output logic [LOG_PTR_W:0] elog_count,
    output logic [LOG_PTR_W:0] dlog_count
);
    localparam int ELOG_W = PARAM_ID_W + 2 * VALUE_W;

    // alarm state
    logic [NUM_ALARMS-1:0] active_q, active_d;
    logic [NUM_ALARMS-1:0] unack_q, unack_d;
    logic [NUM_ALARMS-1:0] ack_q, ack_d;
    logic [NUM_ALARMS-1:0] rise, fall;

    always_comb begin
        rise = limit_violation & ~active_q;
        fall = ~limit_violation & active_q;
        active_d = limit_violation;
        unack_d = (unack_q | rise) & ~(ack_pulse & unack_q);
        ack_d = ack_q | (ack_pulse & unack_q);
        unack_d = unack_d & ~fall;
        ack_d = ack_d & ~fall;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            active_q <= '0;
            unack_q <= '0;
            ack_q <= '0;
        end else begin
            active_q <= active_d;
            unack_q <= unack_d;
            ack_q <= ack_d;
        end
    end

    // indicator and alarm output
    logic [FLASH_CNT_W-1:0] flash_cnt_q, flash_cnt_d;
    logic flash_ph_q, flash_ph_d;
    logic led_q, led_d;
    logic out_q, out_d;
    led_mode_t mode;

    always_comb begin
        if (|unack_d) begin
            mode = LED_FLASH;
        end else if (|ack_d) begin
            mode = LED_STEADY;
        end else begin
            mode = LED_OFF;
        end
        flash_cnt_d = flash_cnt_q + FLASH_CNT_W'(1);
        flash_ph_d = flash_ph_q;
        if (flash_cnt_q == FLASH_CNT_W'(FLASH_HALF - 1)) begin
            flash_cnt_d = '0;
            flash_ph_d = ~flash_ph_q;
        end
        if (mode != LED_FLASH) begin
            flash_cnt_d = '0;
            flash_ph_d = 1'b1;
        end
        case (mode)
            LED_FLASH: led_d = flash_ph_d;
            LED_STEADY: led_d = 1'b1;
            LED_OFF: led_d = 1'b0;
            default: led_d = 1'b0;
        endcase
        out_d = |active_d;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flash_cnt_q <= '0;
            flash_ph_q <= 1'b1;
            led_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            flash_cnt_q <= flash_cnt_d;
            flash_ph_q <= flash_ph_d;
            led_q <= led_d;
            out_q <= out_d;
        end
    end

    // alarm log: one record per cycle, set records before clear records, lowest index first
    logic [ALARM_IDX_W:0] alog_mem [ALOG_DEPTH];
    logic [NUM_ALARMS-1:0] pend_set_q, pend_set_d, pend_clr_q, pend_clr_d;
    logic [LOG_PTR_W:0] alog_cnt_q, alog_cnt_d;
    logic alog_we;
    logic [ALARM_IDX_W:0] alog_wdata;

    always_comb begin
        pend_set_d = pend_set_q | rise;
        pend_clr_d = pend_clr_q | fall;
        alog_we = 1'b0;
        alog_wdata = '0;
        for (int i = NUM_ALARMS - 1; i >= 0; i--) begin
            if (pend_clr_q[i]) begin
                alog_we = 1'b1;
                alog_wdata = {REC_CLEAR, ALARM_IDX_W'(i)};
            end
        end
        for (int i = NUM_ALARMS - 1; i >= 0; i--) begin
            if (pend_set_q[i]) begin
                alog_we = 1'b1;
                alog_wdata = {REC_SET, ALARM_IDX_W'(i)};
            end
        end
        if (alog_we) begin
            if (alog_wdata[ALARM_IDX_W] == REC_SET) begin
                pend_set_d[alog_wdata[ALARM_IDX_W-1:0]] = rise[alog_wdata[ALARM_IDX_W-1:0]];
            end else begin
                pend_clr_d[alog_wdata[ALARM_IDX_W-1:0]] = fall[alog_wdata[ALARM_IDX_W-1:0]];
            end
        end
        // full log stops appending; existing records never rewritten
        if (alog_cnt_q == (LOG_PTR_W+1)'(ALOG_DEPTH)) begin
            alog_we = 1'b0;
        end
        alog_cnt_d = alog_cnt_q + (LOG_PTR_W+1)'(alog_we);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pend_set_q <= '0;
            pend_clr_q <= '0;
            alog_cnt_q <= '0;
        end else begin
            pend_set_q <= pend_set_d;
            pend_clr_q <= pend_clr_d;
            alog_cnt_q <= alog_cnt_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (alog_we) begin
            alog_mem[alog_cnt_q[LOG_PTR_W-1:0]] <= alog_wdata;
        end
    end

    // event and download logs
    logic [ELOG_W-1:0] elog_mem [ELOG_DEPTH];
    logic [COMP_W-1:0] dlog_mem [DLOG_DEPTH];
    logic [LOG_PTR_W:0] elog_cnt_q, elog_cnt_d, dlog_cnt_q, dlog_cnt_d;
    logic elog_we, dlog_we;

    always_comb begin
        elog_we = param_chg_valid && elog_cnt_q != (LOG_PTR_W+1)'(ELOG_DEPTH);
        dlog_we = gas_comp_valid && dlog_cnt_q != (LOG_PTR_W+1)'(DLOG_DEPTH);
        elog_cnt_d = elog_cnt_q + (LOG_PTR_W+1)'(elog_we);
        dlog_cnt_d = dlog_cnt_q + (LOG_PTR_W+1)'(dlog_we);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            elog_cnt_q <= '0;
            dlog_cnt_q <= '0;
        end else begin
            elog_cnt_q <= elog_cnt_d;
            dlog_cnt_q <= dlog_cnt_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (elog_we) begin
            elog_mem[elog_cnt_q[LOG_PTR_W-1:0]] <= {param_chg_id, param_chg_old, param_chg_new};
        end
        if (dlog_we) begin
            dlog_mem[dlog_cnt_q[LOG_PTR_W-1:0]] <= gas_comp_data;
        end
    end

    // registered read ports
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            alog_rd_data <= '0;
            elog_rd_data <= '0;
            dlog_rd_data <= '0;
        end else begin
            alog_rd_data <= alog_mem[alog_rd_addr];
            elog_rd_data <= elog_mem[elog_rd_addr];
            dlog_rd_data <= dlog_mem[dlog_rd_addr];
        end
    end

    assign alarm_led = led_q;
    assign alarm_out = out_q;
    assign unack_list = unack_q;
    assign ack_list = ack_q;
    assign alog_count = alog_cnt_q;
    assign elog_count = elog_cnt_q;
    assign dlog_count = dlog_cnt_q;

    // checks
    logic [NUM_ALARMS-1:0] ack_take;
    assign ack_take = ack_pulse & unack_q & limit_violation;

    property p_rise_unack;
        @(posedge core_clk) disable iff (!rst_n)
        (rise != '0) |=> (unack_list & $past(rise)) == $past(rise);
    endproperty
    a_rise_unack: assert property (p_rise_unack)
        else $error("new alarm not unacked");

    property p_out_active;
        @(posedge core_clk) disable iff (!rst_n)
        (|limit_violation) |=> alarm_out;
    endproperty
    a_out_active: assert property (p_out_active)
        else $error("alarm output low");

    property p_out_clear;
        @(posedge core_clk) disable iff (!rst_n)
        !(|limit_violation) |=> !alarm_out && !alarm_led;
    endproperty
    a_out_clear: assert property (p_out_clear)
        else $error("output not cleared");

    property p_ack_move;
        @(posedge core_clk) disable iff (!rst_n)
        (ack_take != '0) |=> (ack_list & $past(ack_take)) == $past(ack_take)
            && (unack_list & $past(ack_take)) == '0;
    endproperty
    a_ack_move: assert property (p_ack_move)
        else $error("ack did not move alarm");

    property p_steady;
        @(posedge core_clk) disable iff (!rst_n)
        (unack_list == '0 && ack_list != '0) |-> alarm_led;
    endproperty
    a_steady: assert property (p_steady)
        else $error("indicator not steady");

    property p_unlatch;
        @(posedge core_clk) disable iff (!rst_n)
        (fall != '0) |=> ((unack_list | ack_list) & $past(fall)) == '0;
    endproperty
    a_unlatch: assert property (p_unlatch)
        else $error("cleared alarm still listed");

    property p_flash;
        @(posedge core_clk) disable iff (!rst_n)
        (unack_list == '0 && $past(unack_list) == '0 && unack_d != '0) |=> alarm_led;
    endproperty
    a_flash: assert property (p_flash)
        else $error("flash did not start lit");

    property p_alog_set;
        @(posedge core_clk) disable iff (!rst_n)
        (rise != '0 && alog_cnt_q == '0) |-> ##[1:2] alog_cnt_q != '0;
    endproperty
    a_alog_set: assert property (p_alog_set)
        else $error("alarm log not appended");

    property p_elog;
        @(posedge core_clk) disable iff (!rst_n)
        (param_chg_valid && elog_cnt_q < (LOG_PTR_W+1)'(ELOG_DEPTH))
            |=> elog_cnt_q == $past(elog_cnt_q) + (LOG_PTR_W+1)'(1);
    endproperty
    a_elog: assert property (p_elog)
        else $error("event log not appended");

    property p_dlog;
        @(posedge core_clk) disable iff (!rst_n)
        (gas_comp_valid && dlog_cnt_q < (LOG_PTR_W+1)'(DLOG_DEPTH))
            |=> dlog_cnt_q == $past(dlog_cnt_q) + (LOG_PTR_W+1)'(1);
    endproperty
    a_dlog: assert property (p_dlog)
        else $error("download log not appended");
endmodule

// ### pkg/annunciator_pkg.sv
// constants and types for the alarm and event annunciator
// Function
// - Raise an alarm whenever a monitored value violates any limit.
// - A new alarm makes the front-panel indicator flash.
// - A new alarm asserts the digital alarm output.
// - A new alarm enters the unacknowledged list.
// - A new alarm appends an alarm-set record to the alarm log.
// - Acknowledge moves the alarm from unacknowledged to acknowledged list.
// - After acknowledge the indicator is lit steadily.
// - When the violation ends, indicator off and alarm output deasserted.
// - Unlatched: a cleared alarm leaves whichever list holds it.
// - An ending alarm appends an alarm-cleared record to the alarm log.
// - A parameter change logs name, old value and new value.
// - Each received gas composition becomes a new download log entry; the code drops compositions once the log holds 64 entries.
// - Logs are append-only; no means to modify existing entries.
package annunciator_pkg;
    localparam int NUM_ALARMS = 16;
    localparam int ALARM_IDX_W = 4;
    localparam int PARAM_ID_W = 16;
    localparam int VALUE_W = 32;
    localparam int COMP_W = 32;
    localparam int ALOG_DEPTH = 64;
    localparam int ELOG_DEPTH = 64;
    localparam int DLOG_DEPTH = 64;
    localparam int LOG_PTR_W = 6;
    localparam int FLASH_HALF_NS = 250_000_000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int FLASH_HALF_CYC = FLASH_HALF_NS / CLK_PERIOD_NS;
    localparam int FLASH_CNT_W = 25;
    localparam logic [0:0] REC_CLEAR = 1'h0;
    localparam logic [0:0] REC_SET = 1'h1;

    typedef enum logic [1:0] {
        LED_OFF,
        LED_FLASH,
        LED_STEADY
    } led_mode_t;
endpackage

// ### dv/operator_link_model.sv
// operator acknowledge and supervisory gas composition source
module operator_link_model
    import annunciator_pkg::*;
(
    // clock
    input wire logic core_clk,
    // operator acknowledge
    output logic [NUM_ALARMS-1:0] ack_pulse,
    // gas composition link
    output logic gas_comp_valid,
    output logic [COMP_W-1:0] gas_comp_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ack_pulse = '0;
        gas_comp_valid = 1'b0;
        gas_comp_data = '0;
    end
    task automatic ack(input int idx);
        ack_pulse <= NUM_ALARMS'(1) << idx;
        @(posedge core_clk);
        ack_pulse <= '0;
        // one idle edge so a following call never reassigns in this step
        @(posedge core_clk);
    endtask
    // idle data shows the inverse of the last word
    task automatic send_gas(input logic [COMP_W-1:0] w [$]);
        foreach (w[k]) begin
            gas_comp_valid <= 1'b1;
            gas_comp_data <= w[k];
            @(posedge core_clk);
        end
        gas_comp_valid <= 1'b0;
        gas_comp_data <= ~w[w.size()-1];
    endtask
endmodule

// ### dv/testbench.sv
// self-checking bench for the alarm and event annunciator
module testbench
    import annunciator_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {int kind; logic [79:0] exp;} note_t;
    note_t notes [$];
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] limit_violation = '0;
    logic [15:0] ack_pulse;
    logic param_chg_valid = 1'b0;
    logic [15:0] param_chg_id = '0;
    logic [31:0] param_chg_old = '0;
    logic [31:0] param_chg_new = '0;
    logic gas_comp_valid;
    logic [31:0] gas_comp_data;
    logic [5:0] alog_rd_addr = '0;
    logic [5:0] elog_rd_addr = '0;
    logic [5:0] dlog_rd_addr = '0;
    logic alarm_led, alarm_out, led_last;
    logic [15:0] unack_list, ack_list;
    logic [4:0] alog_rd_data;
    logic [79:0] elog_rd_data;
    logic [31:0] dlog_rd_data;
    logic [6:0] alog_count, elog_count, dlog_count;
    logic [31:0] rng = 32'he32b_054c;
    logic [79:0] ev [2];
    logic [31:0] w [$];
    int failures = 0;
    int n_checks = 0;
    int led_toggles = 0;

    always #4 core_clk = ~core_clk;

    alarm_event_annunciator #(.FLASH_HALF(4)) u_alarm_event_annunciator (
        .core_clk(core_clk), .rst_n(rst_n), .limit_violation(limit_violation),
        .ack_pulse(ack_pulse), .param_chg_valid(param_chg_valid),
        .param_chg_id(param_chg_id), .param_chg_old(param_chg_old),
        .param_chg_new(param_chg_new), .gas_comp_valid(gas_comp_valid),
        .gas_comp_data(gas_comp_data), .alog_rd_addr(alog_rd_addr),
        .elog_rd_addr(elog_rd_addr), .dlog_rd_addr(dlog_rd_addr),
        .alarm_led(alarm_led), .alarm_out(alarm_out), .unack_list(unack_list),
        .ack_list(ack_list), .alog_rd_data(alog_rd_data), .elog_rd_data(elog_rd_data),
        .dlog_rd_data(dlog_rd_data), .alog_count(alog_count), .elog_count(elog_count),
        .dlog_count(dlog_count)
    );
    operator_link_model u_operator_link_model (
        .core_clk(core_clk), .ack_pulse(ack_pulse),
        .gas_comp_valid(gas_comp_valid), .gas_comp_data(gas_comp_data)
    );

    function automatic logic [31:0] xorshift();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic note(input int kind, input logic [79:0] exp);
        notes.push_back('{kind, exp});
    endtask
    // 2 = flashing, 1 = steady lit, 0 = off
    task automatic led_check(input logic [79:0] mode);
        led_toggles = 0;
        step(12);
        note(10, mode);
    endtask
    function automatic logic [79:0] observe(input int kind);
        case (kind)
            0: return 80'(alarm_out);
            2: return 80'(unack_list);
            3: return 80'(ack_list);
            4: return 80'(alog_rd_data);
            5: return elog_rd_data;
            6: return 80'(dlog_rd_data);
            7: return 80'(alog_count);
            8: return 80'(elog_count);
            9: return 80'(dlog_count);
            default: return (led_toggles > 0) ? 80'h2 : 80'(alarm_led);
        endcase
    endfunction
    task automatic compare(input int kind, input logic [79:0] exp, input logic [79:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected t=%0t kind %0d exp %h got %h", $time, kind, exp, got);
        end
    endtask
    task automatic compare_level(input int kind, input logic [79:0] exp,
                                 input logic [79:0] got);
        compare(kind, exp, got);
    endtask
    task automatic compare_list(input int kind, input logic [79:0] exp,
                                input logic [79:0] got);
        compare(kind, exp, got);
    endtask
    task automatic compare_record(input int kind, input logic [79:0] exp,
                                  input logic [79:0] got);
        compare(kind, exp, got);
    endtask
    task automatic compare_count(input int kind, input logic [79:0] exp,
                                 input logic [79:0] got);
        compare(kind, exp, got);
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(negedge core_clk) begin
        note_t n;
        logic [79:0] got;
        if (alarm_led !== led_last) led_toggles++;
        led_last = alarm_led;
        while (notes.size() > 0) begin
            n = notes.pop_front();
            got = observe(n.kind);
            case (n.kind)
                0, 10: compare_level(n.kind, n.exp, got);
                2, 3: compare_list(n.kind, n.exp, got);
                4, 5, 6: compare_record(n.kind, n.exp, got);
                default: compare_count(n.kind, n.exp, got);
            endcase
        end
    end

    initial begin
        #20_000;
        failures++;
        complete_run();
    end

    initial begin
        step(4);
        rst_n <= 1'b1;
        step(1);
        limit_violation[3] <= 1'b1;
        step(1);
        note(0, 1);
        note(2, 16'h0008);
        led_check(2);
        note(7, 1);
        note(4, 5'h13);
        limit_violation[9] <= 1'b1;
        u_operator_link_model.ack(5);
        u_operator_link_model.ack(3);
        step(2);
        note(2, 16'h0200);
        note(3, 16'h0008);
        led_check(2);
        u_operator_link_model.ack(9);
        step(2);
        note(3, 16'h0208);
        led_check(1);
        limit_violation[3] <= 1'b0;
        step(2);
        note(0, 1);
        note(3, 16'h0200);
        limit_violation[9] <= 1'b0;
        step(2);
        note(0, 0);
        note(3, 0);
        led_check(0);
        note(7, 4);
        alog_rd_addr <= 6'h03;
        step(2);
        note(4, 5'h09);
        alog_rd_addr <= 6'h01;
        step(2);
        note(4, 5'h19);
        for (int k = 0; k < 2; k++) begin
            // id, old and new take the low 80 of three random words
            ev[k] = 80'({xorshift(), xorshift(), xorshift()});
            param_chg_valid <= 1'b1;
            {param_chg_id, param_chg_old, param_chg_new} <= ev[k];
            step(1);
        end
        param_chg_valid <= 1'b0;
        step(2);
        note(8, 2);
        elog_rd_addr <= 6'h01;
        step(2);
        note(5, ev[1]);
        elog_rd_addr <= 6'h00;
        step(2);
        note(5, ev[0]);
        for (int k = 0; k < 66; k++) w.push_back(xorshift());
        u_operator_link_model.send_gas(w);
        step(2);
        note(9, 64);
        dlog_rd_addr <= 6'h00;
        step(2);
        note(6, w[0]);
        dlog_rd_addr <= 6'h3f;
        step(2);
        note(6, w[63]);
        note(7, 4);
        step(1);
        complete_run();
    end
endmodule
